// ===== fuse_prog_pkg.sv
// constants and types for the fuse memory programming sequencer
// How it works
// - open links singly; apply drive to one output after select high.
// - raise select to boost level to pass fuse current.
// - after first pulse drop drive, enable chip, sense output.
// - unopened link gets further pulses of about five milliseconds.
// - stop programming the device when one link exceeds 400 ms.
// - repeat select, pulse, sense for every bit that must be high.
// - over five seconds total, remove all power five seconds, resume.
// - afterwards read every word in address order and compare; VREAD ends the job at the first word that mismatches.
// - first pulse lasts 50 to 100 microseconds.
// - later pulses last 5 to 15 milliseconds.
// - each sequencing delay exceeds 100 ns, ideally at most 1 us.
// - delays run from end of one edge to start of next.
// - in verify interval switch output to load and read it; the VSTEP/VREAD reads here leave every loadOn bit low.
package fuse_prog_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int WORDS  = 32;
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;
  // times in their own units
  localparam int EDGE_DLY_NS   = 500;   // between 100 ns and 1 us
  localparam int FIRST_PULS_US = 50;
  localparam int NEXT_PULS_MS  = 5;
  localparam int LINK_LIM_MS   = 400;
  localparam int DEV_LIM_MS    = 5000;
  localparam int COOL_MS       = 5000;
  localparam int SENSE_NS      = 1000;
  // cycle counts (least times round up)
  localparam int EDGE_CYC  = (EDGE_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int FIRST_CYC = FIRST_PULS_US * (CLK_HZ / 1_000_000);
  localparam int NEXT_CYC  = NEXT_PULS_MS * (CLK_HZ / 1000);
  localparam int LINK_CYC  = LINK_LIM_MS * (CLK_HZ / 1000);
  localparam int DEV_CYC   = DEV_LIM_MS * (CLK_HZ / 1000);
  localparam int COOL_CYC  = COOL_MS * (CLK_HZ / 1000);
  localparam int SENSE_CYC = (SENSE_NS + CLK_NS - 1) / CLK_NS;
  // pin drive bundle toward the device
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              selectHigh;    // select pin logic high (chip off)
    logic              selectBoost;   // select_boost_level applied
    logic [DATA_W-1:0] fuseDrive;     // fuse_drive_level per output
    logic [DATA_W-1:0] loadOn;        // output switched to sense load
    logic              powerOn;       // device supply present
  } pins_t;
  typedef struct packed {
    logic              fail;
    logic              verifyErr;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        bitIdx;
  } fail_t;
endpackage

// ===== fuse_prom_program_sequencer.sv
// host sequencer that fuses and verifies a 32x8 fusible-link memory
`timescale 1ns/1ps
module fuse_prom_program_sequencer #(
  parameter int FIRST_CYC = fuse_prog_pkg::FIRST_CYC,
  parameter int NEXT_CYC  = fuse_prog_pkg::NEXT_CYC,
  parameter int LINK_CYC  = fuse_prog_pkg::LINK_CYC,
  parameter int DEV_CYC   = fuse_prog_pkg::DEV_CYC,
  parameter int COOL_CYC  = fuse_prog_pkg::COOL_CYC
) (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst,
  // job: pattern written before start
  input  wire logic                              start,
  input  wire logic                              patWe,
  input  wire logic [fuse_prog_pkg::ADDR_W-1:0]  patAddr,
  input  wire logic [fuse_prog_pkg::DATA_W-1:0]  patData,
  // device pins
  output fuse_prog_pkg::pins_t                   pins,
  input  wire logic [fuse_prog_pkg::DATA_W-1:0]  devOut,
  // status
  output logic                                   busy,
  output logic                                   done,
  output fuse_prog_pkg::fail_t                   failInfo
);
  // refuse timings the sequence cannot produce: a pulse is the boost edge cycle
  // plus at least one counted cycle, so one-cycle pulses would come out long
  if (FIRST_CYC < 2 || NEXT_CYC < 2 || LINK_CYC < FIRST_CYC || DEV_CYC < 1
      || COOL_CYC < 1) begin : g_badTiming
    $error("fuse sequencer: bad timing parameters");
  end

  typedef enum logic [3:0] {
    IDLE, NEXTBIT, SELHI, DRIVE, BOOST, PULSE, UNBOOST, UNDRIVE, SENSE,
    COOL, VSTEP, VREAD, DONE_S
  } state_t;

  // sequence state, word under work and its stored pattern
  state_t                          state_r;
  logic [fuse_prog_pkg::DATA_W-1:0] pattern [fuse_prog_pkg::WORDS];
  logic [fuse_prog_pkg::ADDR_W-1:0] addr_r;
  logic [2:0]                      bit_r;
  logic                            firstPulse_r;
  // one shared down-counter times every edge gap, pulse and pause
  logic [31:0]                     tmr_r;
  logic [31:0]                     linkTime_r;
  logic [31:0]                     devTime_r;
  // two-flop synchroniser on the device outputs
  logic [fuse_prog_pkg::DATA_W-1:0] s1_r;
  logic [fuse_prog_pkg::DATA_W-1:0] s2_r;
  logic                            tmrDone;
  logic                            wantHigh;
  logic [31:0]                     pulseLen;

  // pin levels pass two flops before use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
    end else begin
      s1_r <= devOut;
      s2_r <= s1_r;
    end
  end

  // pattern store, written only while idle
  always_ff @(posedge clk) begin
    if (patWe && state_r == IDLE)
      pattern[patAddr] <= patData;
  end

  // the shared timer idles at zero; each timed state but PULSE reloads it on entry, PULSE runs on the BOOST load
  assign tmrDone  = (tmr_r == 32'h0000_0000);
  assign wantHigh = pattern[addr_r][bit_r] && !s2_r[bit_r];
  // pulse length
  // first attempt is short; every retry on the same link uses the long pulse
  assign pulseLen = firstPulse_r ? 32'(FIRST_CYC) : 32'(NEXT_CYC);

  // main sequence
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r      <= IDLE;
      addr_r       <= 5'h00;
      bit_r        <= 3'h0;
      firstPulse_r <= 1'b1;
      tmr_r        <= 32'h0000_0000;
      linkTime_r   <= 32'h0000_0000;
      devTime_r    <= 32'h0000_0000;
      failInfo     <= '0;
      done         <= 1'b0;
    end else begin
      // free-running count-down, held at zero
      if (!tmrDone)
        tmr_r <= tmr_r - 32'h0000_0001;
      // link and device heat budgets
      // both count every cycle the boost is applied, edge cycle included
      if (state_r inside {BOOST, PULSE})
        devTime_r <= devTime_r + 32'h0000_0001;
      if (state_r inside {BOOST, PULSE})
        linkTime_r <= linkTime_r + 32'h0000_0001;
      case (state_r)
        IDLE: begin
          if (start) begin
            addr_r    <= 5'h00;
            bit_r     <= 3'h0;
            devTime_r <= 32'h0000_0000;
            failInfo  <= '0;
            done      <= 1'b0;
            tmr_r     <= 32'(fuse_prog_pkg::SENSE_CYC);
            state_r   <= SENSE;
            firstPulse_r <= 1'b1;
            linkTime_r <= 32'h0000_0000;
          end
        end
        SENSE: begin
          if (tmrDone) begin
            if (wantHigh) begin
              // a link overrun is reported before any cooling pause
              // per link limit
              if (linkTime_r >= 32'(LINK_CYC)) begin
                failInfo <= '{fail: 1'b1, verifyErr: 1'b0, addr: addr_r, bitIdx: bit_r};
                state_r  <= DONE_S;
              end else if (devTime_r >= 32'(DEV_CYC)) begin
                tmr_r     <= 32'(COOL_CYC);
                devTime_r <= 32'h0000_0000;
                state_r   <= COOL;
              end else begin
                tmr_r   <= 32'(fuse_prog_pkg::EDGE_CYC);
                state_r <= SELHI;
              end
            end else
              state_r <= NEXTBIT;
          end
        end
        COOL: begin
          if (tmrDone) begin
            tmr_r   <= 32'(fuse_prog_pkg::SENSE_CYC);
            state_r <= SENSE;
          end
        end
        // select high then drive one output
        SELHI: if (tmrDone) begin
          tmr_r   <= 32'(fuse_prog_pkg::EDGE_CYC);
          state_r <= DRIVE;
        end
        DRIVE: if (tmrDone) begin
          tmr_r   <= pulseLen;
          state_r <= BOOST;
        end
        BOOST: state_r <= PULSE;
        PULSE: if (tmr_r <= 32'h0000_0001) begin
          tmr_r        <= 32'(fuse_prog_pkg::EDGE_CYC);
          firstPulse_r <= 1'b0;
          state_r      <= UNBOOST;
        end
        UNBOOST: if (tmrDone) begin
          tmr_r   <= 32'(fuse_prog_pkg::EDGE_CYC);
          state_r <= UNDRIVE;
        end
        UNDRIVE: if (tmrDone) begin
          tmr_r   <= 32'(fuse_prog_pkg::SENSE_CYC);
          state_r <= SENSE;
        end
        NEXTBIT: begin
          // advance only with no voltage applied
          firstPulse_r <= 1'b1;
          linkTime_r   <= 32'h0000_0000;
          tmr_r        <= 32'(fuse_prog_pkg::SENSE_CYC);
          if (bit_r != 3'h7) begin
            bit_r   <= bit_r + 3'h1;
            state_r <= SENSE;
          end else begin
            bit_r <= 3'h0;
            if (addr_r != 5'h1F) begin
              addr_r  <= addr_r + 5'h01;
              state_r <= SENSE;
            end else begin
              addr_r  <= 5'h00;
              state_r <= VSTEP;
            end
          end
        end
        VSTEP: if (tmrDone) state_r <= VREAD;
        VREAD: begin
          // verify stops at the first bad word; bitIdx carries no meaning here
          // report mismatch
          if (s2_r != pattern[addr_r]) begin
            failInfo <= '{fail: 1'b1, verifyErr: 1'b1, addr: addr_r, bitIdx: 3'h0};
            state_r  <= DONE_S;
          end else if (addr_r == 5'h1F)
            state_r <= DONE_S;
          else begin
            addr_r  <= addr_r + 5'h01;
            tmr_r   <= 32'(fuse_prog_pkg::SENSE_CYC);
            state_r <= VSTEP;
          end
        end
        DONE_S: begin
          done    <= 1'b1;
          state_r <= IDLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // pin drive decode; data outputs of the sequence come from state flops
  // outputs not under fuse drive stay on their limiting resistors
  always_comb begin
    pins          = '0;
    pins.addr     = addr_r;
    pins.powerOn  = (state_r != COOL);
    pins.selectHigh = (state_r inside {SELHI, DRIVE, BOOST, PULSE, UNBOOST, UNDRIVE});
    pins.selectBoost = (state_r inside {BOOST, PULSE});
    if (state_r inside {DRIVE, BOOST, PULSE, UNBOOST})
      pins.fuseDrive[bit_r] = 1'b1;
    if (state_r == SENSE)
      pins.loadOn[bit_r] = 1'b1;
  end

  // plain decode, so start and pattern writes are refused from the edge after the start edge
  assign busy = (state_r != IDLE);
endmodule

// ===== fuse_prom_model.sv
// behavioural blank 32x8 fuse memory on the sequencer pins
`timescale 1ns/1ps
module fuse_prom_model (
  // pins from the sequencer
  input wire logic            clk,
  input fuse_prog_pkg::pins_t pins,
  output logic [7:0]          devOut,
  // fresh part and one strong link
  input wire logic            fresh,
  input wire logic [4:0]      hardAddr,
  input wire logic [2:0]      hardBit,
  input wire logic [15:0]     hardNeed
);
  logic [7:0]  mem [32];
  logic [15:0] cnt [32][8];
  logic [7:0]  lastOut = 8'h00;
  // intact reads low, opens under boost
  always @(posedge clk)
    for (int w = 0; w < 32; w++)
      for (int b = 0; b < 8; b++)
        if (fresh) begin
          mem[w][b] <= 1'b0;
          cnt[w][b] <= 16'h0000;
        end else if (pins.powerOn && pins.selectBoost && pins.addr == w
                     && pins.fuseDrive == (8'h01 << b)) begin
          cnt[w][b] <= cnt[w][b] + 16'h0001;
          if (cnt[w][b] + 16'h0001 >= ((w == hardAddr && b == hardBit) ? hardNeed : 16'h0001))
            mem[w][b] <= 1'b1;
        end
  // word out while enabled; a released line wanders, never holds
  always_comb devOut = (pins.powerOn && !pins.selectHigh) ? mem[pins.addr] : ~lastOut;
  always @(posedge clk) lastOut <= devOut;
endmodule

// ===== fuse_prom_program_sequencer_assertions.sv
// assertions on the fuse sequencer pins
`timescale 1ns/1ps
module fuse_prom_program_sequencer_assertions #(
  parameter int FIRST_CYC = 4,
  parameter int NEXT_CYC  = 8
) (
  // clock, reset and device pins
  input wire logic            clk,
  input wire logic            rst,
  input fuse_prog_pkg::pins_t pins
);
  int boostLen_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // length of the live pulse
  always_ff @(posedge clk or posedge rst)
    if (rst) boostLen_r <= 0;
    else boostLen_r <= pins.selectBoost ? boostLen_r + 1 : 0;
  // drive outlasts the boost so fuse current is cut at the select pin
  sequence s_driveHold;
    (|pins.fuseDrive) [*6] ##1 !(|pins.fuseDrive);
  endsequence
  a_boost_needs_drive: assert property (pins.selectBoost |->
    pins.selectHigh && $onehot(pins.fuseDrive)) else $error("boost alone");
  a_drive_one_hot: assert property (|pins.fuseDrive |->
    pins.selectHigh && $onehot(pins.fuseDrive)) else $error("bad drive");
  a_select_before_drive: assert property ($rose(|pins.fuseDrive) |->
    $past(pins.selectHigh, 5)) else $error("drive too soon");
  a_pulse_length: assert property ($fell(pins.selectBoost) |->
    boostLen_r == FIRST_CYC || boostLen_r == NEXT_CYC) else $error("pulse length");
  a_drive_hold: assert property ($fell(pins.selectBoost) |-> s_driveHold)
    else $error("drive release");
  a_addr_stable: assert property (pins.selectHigh && $past(pins.selectHigh) |->
    $stable(pins.addr)) else $error("address moved");
  a_sense_quiet: assert property (|pins.loadOn |->
    !pins.selectHigh && pins.fuseDrive == 8'h00) else $error("sense while driving");
  a_cool_quiet: assert property (!pins.powerOn |->
    !pins.selectBoost && pins.fuseDrive == 8'h00) else $error("drive while cooling");
endmodule
bind fuse_prom_program_sequencer fuse_prom_program_sequencer_assertions #(
  .FIRST_CYC(FIRST_CYC), .NEXT_CYC(NEXT_CYC)
) i_fuse_prom_program_sequencer_assertions (.clk(clk), .rst(rst), .pins(pins));

// ===== fuse_prom_program_sequencer_bench.sv
// bench: random patterns with strong, stuck and extra links
`timescale 1ns/1ps
module fuse_prom_program_sequencer_bench;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, patWe = 1'b0, fresh = 1'b1;
  logic busy, done;
  logic [4:0] patAddr = 5'h00, hAddr = 5'h03;
  logic [2:0] hBit = 3'h6;
  logic [7:0] patData = 8'h00, devOut, pat [32];
  logic [15:0] hNeed = 16'h0006;
  fuse_prog_pkg::pins_t pins;
  fuse_prog_pkg::fail_t failInfo;
  integer mismatches = 0, cmp_count = 0, seed = 32'h356C;
  // short counts keep the run to thousands of cycles
  fuse_prom_program_sequencer #(.FIRST_CYC(4), .NEXT_CYC(8), .LINK_CYC(40), .DEV_CYC(200),
    .COOL_CYC(20)) i_fuse_prom_program_sequencer (.clk(clk), .rst(rst), .start(start),
    .patWe(patWe), .patAddr(patAddr), .patData(patData), .pins(pins), .devOut(devOut),
    .busy(busy), .done(done), .failInfo(failInfo));
  fuse_prom_model i_fuse_prom_model (.clk(clk), .pins(pins), .devOut(devOut),
    .fresh(fresh), .hardAddr(hAddr), .hardBit(hBit), .hardNeed(hNeed));
  initial forever #50 clk = ~clk;
  // compare and count
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // expected failure record
  function automatic fuse_prog_pkg::fail_t fx(logic v, logic [4:0] a, logic [2:0] b);
    return {1'b1, v, a, b};
  endfunction
  // blank part in the socket and a fresh random pattern
  task automatic newDevice;
    @(posedge clk) fresh <= 1'b1;
    @(posedge clk) fresh <= 1'b0;
    for (int w = 0; w < 32; w++) pat[w] = 8'($random(seed));
  endtask
  // load, start, poke while busy, then wait bounded for done
  task automatic runJob;
    int n;
    for (int w = 0; w <= 32; w++) begin
      @(posedge clk);
      patWe <= w < 32;
      patAddr <= 5'(w);
      patData <= pat[w % 32];
    end
    start <= 1'b1;
    @(posedge clk);
    patWe <= 1'b1;
    patData <= ~pat[0];
    @(posedge clk);
    {start, patWe} <= 2'b00;
    @(negedge clk);
    chk(busy === 1'b1, "start not taken");
    for (n = 0; n < 60000 && done !== 1'b1; n++) @(negedge clk);
    if (n == 60000) begin
      mismatches++;
      $display("unexpected at %0t: no done within bound", $time);
      stop_test();
    end
    chk(busy === 1'b0, "busy after done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    newDevice();
    pat[3][6] = 1'b1;
    runJob();
    chk({failInfo.fail, failInfo.verifyErr} === 2'b00, "clean job flagged");
    for (int w = 0; w < 32; w++) chk(i_fuse_prom_model.mem[w] === pat[w], "word");
    newDevice();
    pat[9][2] = 1'b1;
    {hAddr, hBit, hNeed} <= {5'h09, 3'h2, 16'hFFFF};
    runJob();
    chk(failInfo === fx(1'b0, 5'h09, 3'h2), "stuck link missed");
    chk(i_fuse_prom_model.mem[31] === 8'h00, "kept fusing");
    newDevice();
    hNeed <= 16'h0001;
    pat[5][3] = 1'b0;
    @(posedge clk);
    i_fuse_prom_model.mem[5][3] <= 1'b1;
    runJob();
    chk(failInfo === fx(1'b1, 5'h05, 3'h0), "verify miss");
    stop_test();
  end
endmodule
